// [ecp_pkg.sv]
`default_nettype none
package ecp_pkg;

  // ----------------------------------------------------------------
  // Register offsets from the port base address
  // ----------------------------------------------------------------
  localparam logic [10:0] OFF_DATA    = 11'h000;
  localparam logic [10:0] OFF_STATUS  = 11'h001;
  localparam logic [10:0] OFF_CONTROL = 11'h002;
  localparam logic [10:0] OFF_FIFO    = 11'h400;
  localparam logic [10:0] OFF_CFGB    = 11'h401;
  localparam logic [10:0] OFF_ECR     = 11'h402;

  // ----------------------------------------------------------------
  // Mode field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_STD    = 3'h0;
  localparam logic [2:0] MODE_BIDIR  = 3'h1;
  localparam logic [2:0] MODE_HSFIFO = 3'h2;
  localparam logic [2:0] MODE_ECP    = 3'h3;
  localparam logic [2:0] MODE_EPP    = 3'h4;
  localparam logic [2:0] MODE_RSVD   = 3'h5;
  localparam logic [2:0] MODE_TEST   = 3'h6;
  localparam logic [2:0] MODE_CFG    = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_ACKIE  = 4;
  localparam int CTL_DIR    = 5;
  localparam int CFGB_INTR  = 6;
  // Stored extended control bits: mode[5:3], fault int off[2], dma[1], service[0]
  localparam int ECR_NERR   = 2;
  localparam int ECR_DMA    = 1;
  localparam int ECR_SVC    = 0;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET  = 6'h00;
  localparam logic [5:0] ECR_RESET  = 6'h05;
  localparam logic [7:0] CFGA_VALUE = 8'h10;

  // ----------------------------------------------------------------
  // Handshake timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ    = 100;
  localparam int SETUP_NS   = 500;
  localparam int STROBE_NS  = 500;
  localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    ENG_IDLE   = 4'h1,
    ENG_SETUP  = 4'h2,
    ENG_STROBE = 4'h4,
    ENG_RACK   = 4'h8
  } ecp_eng_t;

endpackage
`default_nettype wire

// [ecp_port_regs.sv]
`default_nettype none
// Notes on behaviour
// - Three-bit mode: standard, bidir, handshake FIFO, ECP, EPP, reserved, test, config.
// - Slot 0x400 is FIFO or config A by mode; 0x401 config B; 0x402 always.
// - Addresses are base plus offset; respond only while AEN is low.
// - Modes 000/001: reset-cleared data latch drives port lines; reads sample lines.
// - Mode 011: offset 0 writes push address/RLE tagged bytes, forward only.
// - Status bits 0-2 read zero; bits 3-6 show fault, select, paper, ack.
// - Status bit 7 reads the inverse of busy.
// - Control bits 0-5 reset to zero; bits 6-7 read zero, ignore writes.
// - Control bits 0,1,3 drive strobe, autofeed, select inverted; bit 2 straight.
// - With control bit 4 set, rising acknowledge raises an interrupt request.
// - Control bit 5 is direction; forced output in modes 000 and 010.
// - Mode 010 FIFO bytes go out with automatic standard handshake, forward only.
// - Mode 011 sends FIFO bytes forward, or captures peripheral bytes in reverse.
// - Mode 110 FIFO is host read/write with no handshake; head shown on lines.
// - Test FIFO never stalls: full writes dropped, empty reads repeat last byte.
// - Non-empty FIFO reads come from the head in first-in order.
// - Service flag sets on free or valid threshold depending on direction.
// - Config A in mode 111 is read-only and returns 10H.
// - Config B bit 7 reads zero; decompression is still performed.
// - One common 16 byte FIFO serves every FIFO mode and direction.
// - A run-length byte is not data; it repeats the next data byte.
module ecp_port_regs #(
  parameter int DEPTH     = 16,
  parameter int FREE_THR  = 8,
  parameter int VALID_THR = 8
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [15:0] base_addr,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic        aen,
  output logic      [7:0]  io_rdata,
  input  wire logic [2:0]  irq_code,
  input  wire logic [2:0]  dma_code,
  input  wire logic [7:0]  port_data_in,
  output logic      [7:0]  port_data_out,
  output logic             port_data_oe,
  input  wire logic        peripheral_fault_in_n,
  input  wire logic        select_in,
  input  wire logic        paper_error_in,
  input  wire logic        peripheral_acknowledge_in_n,
  input  wire logic        busy_in,
  output logic             data_strobe_out_n,
  output logic             auto_feed_out_n,
  output logic             printer_initialize_out_n,
  output logic             printer_select_out_n,
  output logic             ack_irq
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] FREE_C  = (AW+1)'(FREE_THR);
  localparam logic [AW:0] VALID_C = (AW+1)'(VALID_THR);
  localparam logic [7:0]  SETUP_C  = 8'(ecp_pkg::SETUP_CYC);
  localparam logic [7:0]  STROBE_C = 8'(ecp_pkg::STROBE_CYC);
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b, input logic [10:0] o, input logic en);
    hit = !en && (a == 16'(b + {5'h00, o}));
  endfunction
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] sync1_ff;
  logic [12:0] sync2_ff;
  logic        ack_prev_ff;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // Acknowledge idles high; a low reset value would fake a rising edge
      sync1_ff    <= 13'h0002;
      sync2_ff    <= 13'h0002;
      ack_prev_ff <= 1'b1;
    end else begin
      sync1_ff    <= {port_data_in, peripheral_fault_in_n, select_in, paper_error_in,
                      peripheral_acknowledge_in_n, busy_in};
      sync2_ff    <= sync1_ff;
      ack_prev_ff <= sync2_ff[1];
    end
  end
  logic [7:0] pd_s;
  logic       fault_s;
  logic       select_s;
  logic       paper_error_in_s;
  logic       ack_s;
  logic       busy_s;
  assign pd_s     = sync2_ff[12:5];
  assign fault_s  = sync2_ff[4];
  assign select_s = sync2_ff[3];
  assign paper_error_in_s = sync2_ff[2];
  assign ack_s    = sync2_ff[1];
  assign busy_s   = sync2_ff[0];
  // ----------------------------------------------------------------
  // Registers and FIFO state
  // ----------------------------------------------------------------
  logic [7:0]    latch_ff, nxt_latch;
  logic [5:0]    ctl_ff, nxt_ctl;
  logic [5:0]    ecr_ff, nxt_ecr;
  logic [7:0]    rdata_ff, nxt_rdata;
  logic [7:0]    last_ff, nxt_last;
  logic [8:0]    mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff, nxt_wptr;
  logic [AW-1:0] rptr_ff, nxt_rptr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          irq_ff, nxt_irq;
  logic [2:0] mode;
  logic       dir_eff;
  logic       full;
  logic       empty;
  logic [8:0] head;
  assign mode    = ecr_ff[5:3];
  assign dir_eff = (mode == ecp_pkg::MODE_STD || mode == ecp_pkg::MODE_HSFIFO) ? 1'b0
                   : ctl_ff[ecp_pkg::CTL_DIR];
  assign full    = (cnt_ff == DEPTH_C);
  assign empty   = (cnt_ff == '0);
  assign head    = mem_ff[rptr_ff];
  logic wr_data, wr_ctl, wr_fifo, wr_ecr;
  logic rd_data, rd_stat, rd_ctl, rd_fifo, rd_cfgb, rd_ecr;
  always_comb begin
    wr_data = io_wr && hit(io_addr, base_addr, ecp_pkg::OFF_DATA, aen);
    wr_ctl  = io_wr && hit(io_addr, base_addr, ecp_pkg::OFF_CONTROL, aen);
    wr_fifo = io_wr && hit(io_addr, base_addr, ecp_pkg::OFF_FIFO, aen);
    wr_ecr  = io_wr && hit(io_addr, base_addr, ecp_pkg::OFF_ECR, aen);
    rd_data = io_rd && hit(io_addr, base_addr, ecp_pkg::OFF_DATA, aen);
    rd_stat = io_rd && hit(io_addr, base_addr, ecp_pkg::OFF_STATUS, aen);
    rd_ctl  = io_rd && hit(io_addr, base_addr, ecp_pkg::OFF_CONTROL, aen);
    rd_fifo = io_rd && hit(io_addr, base_addr, ecp_pkg::OFF_FIFO, aen);
    rd_cfgb = io_rd && hit(io_addr, base_addr, ecp_pkg::OFF_CFGB, aen);
    rd_ecr  = io_rd && hit(io_addr, base_addr, ecp_pkg::OFF_ECR, aen);
  end
  // ----------------------------------------------------------------
  // Port handshake engine
  // ----------------------------------------------------------------
  ecp_pkg::ecp_eng_t state_ff, nxt_state;
  logic [7:0] tcnt_ff, nxt_tcnt;
  logic [7:0] edata_ff, nxt_edata;
  logic       etag_ff, nxt_etag;
  logic [6:0] rle_ff, nxt_rle;
  logic [6:0] rep_ff, nxt_rep;
  logic       fwd_active;
  logic       rev_active;
  logic       eng_pop;
  logic       rev_push;
  logic [7:0] rev_byte;
  assign fwd_active = !dir_eff && (mode == ecp_pkg::MODE_HSFIFO || mode == ecp_pkg::MODE_ECP);
  assign rev_active = dir_eff && (mode == ecp_pkg::MODE_ECP);
  always_comb begin
    nxt_state = state_ff;
    nxt_tcnt  = tcnt_ff;
    nxt_edata = edata_ff;
    nxt_etag  = etag_ff;
    nxt_rle   = rle_ff;
    nxt_rep   = rep_ff;
    eng_pop   = 1'b0;
    rev_push  = 1'b0;
    rev_byte  = edata_ff;
    case (state_ff)
      ecp_pkg::ENG_IDLE: begin
        if (fwd_active && !empty) begin
          eng_pop   = 1'b1;
          nxt_edata = head[7:0];
          nxt_etag  = head[8];
          nxt_tcnt  = SETUP_C;
          nxt_state = ecp_pkg::ENG_SETUP;
        end else if (rev_active && !full && !ack_s) begin
          nxt_edata = pd_s;
          nxt_state = ecp_pkg::ENG_RACK;
          if (!busy_s) begin
            // Command byte: bit 7 low carries a run count, high a channel address
            if (!pd_s[7]) begin
              nxt_rle = pd_s[6:0];
            end
          end else begin
            rev_push = 1'b1;
            rev_byte = pd_s;
            nxt_rep  = rle_ff;
            nxt_rle  = 7'h00;
          end
        end
      end
      ecp_pkg::ENG_SETUP: begin
        if (tcnt_ff != 8'h00) begin
          nxt_tcnt = tcnt_ff - 8'h01;
        end else if (!busy_s) begin
          nxt_tcnt  = STROBE_C;
          nxt_state = ecp_pkg::ENG_STROBE;
        end
      end
      ecp_pkg::ENG_STROBE: begin
        // ECP strobe is interlocked with busy; standard strobe is a timed pulse
        if (mode == ecp_pkg::MODE_ECP) begin
          if (busy_s) begin
            nxt_state = ecp_pkg::ENG_IDLE;
          end
        end else if (tcnt_ff != 8'h00) begin
          nxt_tcnt = tcnt_ff - 8'h01;
        end else begin
          nxt_state = ecp_pkg::ENG_IDLE;
        end
      end
      ecp_pkg::ENG_RACK: begin
        // Repeats drain while the host still holds ack, stalling on full
        if (rep_ff != 7'h00) begin
          if (!full) begin
            rev_push = 1'b1;
            nxt_rep  = rep_ff - 7'h01;
          end
        end else if (ack_s) begin
          nxt_state = ecp_pkg::ENG_IDLE;
        end
      end
      default: nxt_state = ecp_pkg::ENG_IDLE;
    endcase
    if (!fwd_active && !rev_active) begin
      nxt_state = ecp_pkg::ENG_IDLE;
      nxt_rep   = 7'h00;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ecp_pkg::ENG_IDLE;
      tcnt_ff  <= 8'h00;
      edata_ff <= 8'h00;
      etag_ff  <= 1'b0;
      rle_ff   <= 7'h00;
      rep_ff   <= 7'h00;
    end else begin
      state_ff <= nxt_state;
      tcnt_ff  <= nxt_tcnt;
      edata_ff <= nxt_edata;
      etag_ff  <= nxt_etag;
      rle_ff   <= nxt_rle;
      rep_ff   <= nxt_rep;
    end
  end
  // ----------------------------------------------------------------
  // Host side of the shared FIFO
  // ----------------------------------------------------------------
  logic       host_push;
  logic [8:0] host_word;
  logic       host_pop;
  logic       push;
  logic       pop;
  logic [8:0] push_word;
  always_comb begin
    host_push = 1'b0;
    host_word = {1'b0, io_wdata};
    if (wr_data && mode == ecp_pkg::MODE_ECP && !dir_eff) begin
      host_push = 1'b1;
      host_word = {1'b1, io_wdata};
    end else if (wr_fifo && (mode == ecp_pkg::MODE_HSFIFO || mode == ecp_pkg::MODE_TEST ||
                 (mode == ecp_pkg::MODE_ECP && !dir_eff))) begin
      host_push = 1'b1;
    end
    host_pop  = rd_fifo && !empty && (mode == ecp_pkg::MODE_TEST ||
                (mode == ecp_pkg::MODE_ECP && dir_eff));
    push      = (host_push || rev_push) && !full;
    pop       = host_pop || eng_pop;
    push_word = rev_push ? {1'b0, rev_byte} : host_word;
    nxt_wptr  = push ? AW'(wptr_ff + 1'b1) : wptr_ff;
    nxt_rptr  = pop ? AW'(rptr_ff + 1'b1) : rptr_ff;
    nxt_cnt   = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
    nxt_last  = host_pop ? head[7:0] : last_ff;
    if (mode == ecp_pkg::MODE_STD) begin
      // Standard mode holds the FIFO in reset
      nxt_wptr = '0;
      nxt_rptr = '0;
      nxt_cnt  = '0;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
      last_ff <= 8'h00;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff  <= nxt_cnt;
      last_ff <= nxt_last;
    end
  end
  // Storage carries no reset; only the pointers define contents
  always_ff @(posedge mclk) begin
    if (push) mem_ff[wptr_ff] <= push_word;
  end
  // ----------------------------------------------------------------
  // Register writes, service flag and acknowledge interrupt
  // ----------------------------------------------------------------
  logic thr_met;
  logic svc_set;
  always_comb begin
    thr_met   = dir_eff ? (cnt_ff >= VALID_C) : (AW+1)'(DEPTH_C - cnt_ff) >= FREE_C;
    svc_set   = !ecr_ff[ecp_pkg::ECR_SVC] && !ecr_ff[ecp_pkg::ECR_DMA] && thr_met &&
                (mode == ecp_pkg::MODE_HSFIFO || mode == ecp_pkg::MODE_ECP ||
                 mode == ecp_pkg::MODE_TEST);
    nxt_latch = latch_ff;
    if (wr_data && (mode == ecp_pkg::MODE_STD || mode == ecp_pkg::MODE_BIDIR)) begin
      nxt_latch = io_wdata;
    end
    nxt_ctl = wr_ctl ? io_wdata[5:0] : ctl_ff;
    nxt_ecr = wr_ecr ? io_wdata[7:2] : ecr_ff;
    // Hardware set beats a software clear arriving in the same cycle
    if (svc_set) begin
      nxt_ecr[ecp_pkg::ECR_SVC] = 1'b1;
    end
    nxt_irq = ctl_ff[ecp_pkg::CTL_ACKIE] && ack_s && !ack_prev_ff;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latch_ff <= ecp_pkg::DATA_RESET;
      ctl_ff   <= ecp_pkg::CTL_RESET;
      ecr_ff   <= ecp_pkg::ECR_RESET;
      irq_ff   <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
      ctl_ff   <= nxt_ctl;
      ecr_ff   <= nxt_ecr;
      irq_ff   <= nxt_irq;
    end
  end
  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    if (io_rd) begin
      nxt_rdata = 8'h00;
      if (rd_data && (mode == ecp_pkg::MODE_STD || mode == ecp_pkg::MODE_BIDIR)) begin
        nxt_rdata = pd_s;
      end else if (rd_stat) begin
        nxt_rdata = {!busy_s, ack_s, paper_error_in_s, select_s, fault_s, 3'h0};
      end else if (rd_ctl) begin
        nxt_rdata = {2'h0, ctl_ff};
      end else if (rd_fifo && mode == ecp_pkg::MODE_CFG) begin
        nxt_rdata = ecp_pkg::CFGA_VALUE;
      end else if (rd_fifo && (mode == ecp_pkg::MODE_TEST || (mode == ecp_pkg::MODE_ECP && dir_eff))) begin
        nxt_rdata = empty ? last_ff : head[7:0];
      end else if (rd_cfgb && mode == ecp_pkg::MODE_CFG) begin
        nxt_rdata = {1'b0, irq_ff, irq_code, dma_code};
      end else if (rd_ecr) begin
        nxt_rdata = {ecr_ff, full, empty};
      end
    end
  end
  // ----------------------------------------------------------------
  // Port pin drivers
  // ----------------------------------------------------------------
  logic [7:0] pdo_ff, nxt_pdo;
  logic       oe_ff, nxt_oe;
  logic [3:0] ctlo_ff, nxt_ctlo;
  logic       xfer;
  always_comb begin
    xfer = (state_ff == ecp_pkg::ENG_SETUP) || (state_ff == ecp_pkg::ENG_STROBE);
    case (mode)
      ecp_pkg::MODE_HSFIFO, ecp_pkg::MODE_ECP: nxt_pdo = edata_ff;
      ecp_pkg::MODE_TEST:                      nxt_pdo = head[7:0];
      default:                                 nxt_pdo = latch_ff;
    endcase
    nxt_oe = !dir_eff;
    // Order: select, init, autofeed, strobe (all pin levels)
    nxt_ctlo[0] = !(ctl_ff[ecp_pkg::CTL_STROBE] || (fwd_active && state_ff == ecp_pkg::ENG_STROBE));
    nxt_ctlo[1] = !ctl_ff[ecp_pkg::CTL_AUTOFD];
    if (mode == ecp_pkg::MODE_ECP && xfer) begin
      nxt_ctlo[1] = !etag_ff;
    end else if (rev_active) begin
      nxt_ctlo[1] = (state_ff == ecp_pkg::ENG_RACK);
    end
    nxt_ctlo[2] = ctl_ff[ecp_pkg::CTL_INIT];
    nxt_ctlo[3] = !ctl_ff[ecp_pkg::CTL_SELIN];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
      pdo_ff   <= 8'h00;
      oe_ff    <= 1'b0;
      ctlo_ff  <= 4'h9;
    end else begin
      rdata_ff <= nxt_rdata;
      pdo_ff   <= nxt_pdo;
      oe_ff    <= nxt_oe;
      ctlo_ff  <= nxt_ctlo;
    end
  end

  assign io_rdata                 = rdata_ff;
  assign port_data_out            = pdo_ff;
  assign port_data_oe             = oe_ff;
  assign data_strobe_out_n        = ctlo_ff[0];
  assign auto_feed_out_n          = ctlo_ff[1];
  assign printer_initialize_out_n = ctlo_ff[2];
  assign printer_select_out_n     = ctlo_ff[3];
  assign ack_irq                  = irq_ff;
endmodule // ecp_port_regs
`default_nettype wire

// [ecp_port_regs_assertions.sv]
`default_nettype none
module ecp_port_regs_assertions (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [15:0] base_addr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic        aen,
  input wire logic [7:0]  io_rdata,
  input wire logic [7:0]  port_data_out,
  input wire logic        port_data_oe,
  input wire logic        busy_in,
  input wire logic        data_strobe_out_n,
  input wire logic        auto_feed_out_n,
  input wire logic        printer_initialize_out_n,
  input wire logic        printer_select_out_n,
  input wire logic        ack_irq
);
  // ----------------------------------------------------------------
  // Shadow of mode and control, rebuilt from host writes
  // ----------------------------------------------------------------
  wire logic [15:0] off   = io_addr - base_addr;
  wire logic        rd_ok = io_rd && !aen;
  wire logic        wr_ok = io_wr && !aen;
  logic [2:0] mode_ff, nxt_mode;
  logic [5:0] ctl_ff, nxt_ctl;
  always_comb begin
    nxt_mode = (wr_ok && off == 16'h0402) ? io_wdata[7:5] : mode_ff;
    nxt_ctl  = (wr_ok && off == 16'h0002) ? io_wdata[5:0] : ctl_ff;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= 3'h0;
      ctl_ff  <= 6'h00;
    end else begin
      mode_ff <= nxt_mode;
      ctl_ff  <= nxt_ctl;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_status_zero: assert property (rd_ok && off == 16'h0001 |=> io_rdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_status_busy: assert property (rd_ok && off == 16'h0001 && $stable(busy_in) && busy_in == $past(busy_in, 2)
    && busy_in == $past(busy_in, 3) |=> io_rdata[7] == !$past(busy_in)) else $error("busy bit not inverted");
  a_ctl_high: assert property (rd_ok && off == 16'h0002 |=> io_rdata[7:6] == 2'h0)
    else $error("control high bits not zero");
  // Engine modes own the pins, so only the plain modes are compared
  a_ctl_pins: assert property (mode_ff <= 3'h1 && $past(mode_ff) <= 3'h1 && $stable(ctl_ff) && $past(resetn)
    |-> data_strobe_out_n == !ctl_ff[0] && auto_feed_out_n == !ctl_ff[1] && printer_initialize_out_n == ctl_ff[2]
    && printer_select_out_n == !ctl_ff[3]) else $error("control pins mismatch");
  a_ack_gated: assert property (ack_irq |-> $past(ctl_ff[4]) || $past(ctl_ff[4], 2))
    else $error("ack interrupt while disabled");
  a_dir_forced: assert property ((mode_ff == 3'h0 || mode_ff == 3'h2) && $past(mode_ff) == mode_ff
    && $past(resetn) |-> port_data_oe) else $error("data lines not driven");
  a_latch_drives: assert property (mode_ff == 3'h0 && wr_ok && off == 16'h0000
    |-> ##2 port_data_out == $past(io_wdata, 2)) else $error("latch not on lines");
  a_cfga_value: assert property (mode_ff == 3'h7 && rd_ok && off == 16'h0400 |=> io_rdata == 8'h10)
    else $error("config A wrong");
endmodule // ecp_port_regs_assertions
bind ecp_port_regs ecp_port_regs_assertions u_chk (.mclk(mclk), .resetn(resetn), .base_addr(base_addr),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr), .aen(aen), .io_rdata(io_rdata),
  .port_data_out(port_data_out), .port_data_oe(port_data_oe), .busy_in(busy_in),
  .data_strobe_out_n(data_strobe_out_n), .auto_feed_out_n(auto_feed_out_n),
  .printer_initialize_out_n(printer_initialize_out_n), .printer_select_out_n(printer_select_out_n),
  .ack_irq(ack_irq));
`default_nettype wire

// [ecp_periph_model.sv]
`default_nettype none
module ecp_periph_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       strobe_n,
  input  wire logic       feed_n,
  input  wire logic [7:0] data,
  input  wire logic [3:0] status_lvl,
  input  wire logic       ack_req,
  output logic            ack_n,
  output logic            busy,
  output logic [7:0]      got_byte,
  output logic            got_feed_n,
  output int              got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       hs_busy;
  logic       strobe_q;
  logic [2:0] hold;
  assign busy = status_lvl[3] | hs_busy;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hs_busy <= 1'b0;
      strobe_q <= 1'b1;
      hold <= 3'h0;
      ack_n <= 1'b1;
      got_cnt <= 0;
    end else begin
      strobe_q <= strobe_n;
      // Busy rises at once so an interlocked strobe cannot hang
      if (!strobe_n && strobe_q) begin
        hs_busy <= 1'b1;
        got_byte <= data;
        got_feed_n <= feed_n;
        got_cnt <= got_cnt + 1;
        hold <= 3'h4;
      end else if (strobe_n && hold != 3'h0) hold <= hold - 3'h1;
      else if (strobe_n) hs_busy <= 1'b0;
      ack_n <= !(ack_req || (strobe_n && hold == 3'h2));
    end
  end
endmodule // ecp_periph_model
`default_nettype wire

// [ecp_port_regs_tb_top.sv]
`default_nettype none
module ecp_port_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, io_rd, io_wr, aen, ack_req, pd_oe, ack_n, busy, ack_irq, got_feed_n, seen;
  logic        stb_n, afd_n, init_n, sel_n;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, pd_out, got_byte, rv;
  logic [3:0]  status_lvl;
  int          got_cnt, num_errors, n_compared, cycles, i;
  wire logic [7:0] pd_line = pd_oe ? pd_out : 8'h3C;
  ecp_port_regs u_dut (.mclk(mclk), .resetn(resetn), .base_addr(16'h0378), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr), .aen(aen), .io_rdata(io_rdata), .irq_code(3'h5),
    .dma_code(3'h2), .port_data_in(pd_line), .port_data_out(pd_out), .port_data_oe(pd_oe),
    .peripheral_fault_in_n(status_lvl[0]), .select_in(status_lvl[1]), .paper_error_in(status_lvl[2]),
    .peripheral_acknowledge_in_n(ack_n), .busy_in(busy), .data_strobe_out_n(stb_n), .auto_feed_out_n(afd_n),
    .printer_initialize_out_n(init_n), .printer_select_out_n(sel_n), .ack_irq(ack_irq));
  ecp_periph_model u_prn (.mclk(mclk), .resetn(resetn), .strobe_n(stb_n), .feed_n(afd_n), .data(pd_out),
    .status_lvl(status_lvl), .ack_req(ack_req), .ack_n(ack_n), .busy(busy), .got_byte(got_byte),
    .got_feed_n(got_feed_n), .got_cnt(got_cnt));
  // ----------------------------------------------------------------
  // Host access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [10:0] off, input logic [7:0] d);
    io_addr = 16'h0378 + {5'h00, off};
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [10:0] off);
    io_addr = 16'h0378 + {5'h00, off};
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    @(negedge mclk);
    rv = io_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ack_pulse();
    seen = 1'b0;
    ack_req = 1'b1;
    repeat (3) @(negedge mclk);
    ack_req = 1'b0;
    repeat (8) begin
      @(negedge mclk);
      if (ack_irq === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic wait_byte(input logic [7:0] exp, input logic feed);
    int n;
    n = got_cnt;
    for (int k = 0; k < 400 && got_cnt == n; k++) @(negedge mclk);
    chk(got_byte, exp);
    chk({7'h0, got_feed_n}, {7'h0, feed});
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and test sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    {resetn, io_rd, io_wr, aen, ack_req, io_addr, io_wdata, status_lvl} = '0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    rd(11'h000); chk(rv, 8'h00);
    rd(11'h402); chk(rv, 8'h15);
    for (i = 0; i < 16; i++) begin
      status_lvl = i[3:0];
      repeat (4) @(negedge mclk);
      rd(11'h001); chk(rv, {!status_lvl[3], 1'b1, status_lvl[2:0], 3'h0});
    end
    status_lvl = 4'h1;
    wr(11'h002, 8'hFF); rd(11'h002); chk(rv, 8'h3F);
    chk({3'h0, pd_oe, sel_n, init_n, afd_n, stb_n}, 8'h14);
    ack_pulse(); chk({7'h0, seen}, 8'h01);
    wr(11'h002, 8'h00); ack_pulse(); chk({7'h0, seen}, 8'h00);
    aen = 1'b1;
    wr(11'h002, 8'h0A);
    aen = 1'b0;
    rd(11'h002); chk(rv, 8'h00);
    wr(11'h000, 8'hA5); repeat (2) @(negedge mclk); chk(pd_out, 8'hA5);
    wr(11'h402, 8'h20); wr(11'h002, 8'h20); repeat (4) @(negedge mclk);
    rd(11'h000); chk(rv, 8'h3C); chk({7'h0, pd_oe}, 8'h00);
    wr(11'h002, 8'h00); wr(11'h402, 8'hE0); wr(11'h400, 8'h55);
    rd(11'h400); chk(rv, 8'h10);
    rd(11'h401); chk(rv, 8'h2A);
    rd(11'h003); chk(rv, 8'h00);
    wr(11'h402, 8'h00); rd(11'h400); chk(rv, 8'h00);
    wr(11'h402, 8'hC4);
    for (i = 0; i < 17; i++) wr(11'h400, 8'h40 + i[7:0]);
    rd(11'h402); chk(rv, 8'hC6);
    wr(11'h402, 8'hC0);
    for (i = 0; i < 16; i++) begin
      rd(11'h400); chk(rv, 8'h40 + i[7:0]);
      rd(11'h402); chk({7'h0, rv[2]}, {7'h0, i >= 7});
    end
    rd(11'h400); chk(rv, 8'h4F);
    rd(11'h402); chk({6'h0, rv[1:0]}, 8'h01);
    wr(11'h402, 8'h00); wr(11'h402, 8'h44);
    wr(11'h400, 8'h9A); wait_byte(8'h9A, 1'b1);
    wr(11'h402, 8'h00); wr(11'h402, 8'h64);
    wr(11'h000, 8'h17); wait_byte(8'h17, 1'b0);
    wr(11'h400, 8'hB2); wait_byte(8'hB2, 1'b1);
    wr(11'h002, 8'h20); status_lvl = 4'h9; ack_pulse();
    rd(11'h400); chk(rv, 8'h3C);
    status_lvl = 4'h1; ack_pulse(); status_lvl = 4'h9; ack_pulse(); repeat (12) @(negedge mclk);
    rd(11'h402); chk({6'h0, rv[1:0]}, 8'h02);
    print_verdict();
  end
endmodule // ecp_port_regs_tb_top
`default_nettype wire
